/* shared/bspc_pkg.sv */
// constants shared by both ends of the boot self-program controller
package bspc_pkg;
  // register offsets on the core's i/o space
  localparam logic [5:0]  CTRL_OFFSET   = 6'h37;
  localparam logic [5:0]  EXTPTR_OFFSET = 6'h3b;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  UNMAPPED_BYTE = 8'h00;
  localparam logic [7:0]  BLOCKED_BYTE  = 8'hff;
  // control register field positions
  localparam int BIT_IRQ_EN = 7;
  localparam int BIT_BUSY   = 6;
  localparam int BIT_SIG    = 5;
  localparam int BIT_REEN   = 4;
  // accepted low five bit command patterns
  localparam logic [4:0] CMD_REEN = 5'h11;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_PGWR = 5'h05;
  localparam logic [4:0] CMD_PGER = 5'h03;
  localparam logic [4:0] CMD_FILL = 5'h01;
  // command window lengths in clock cycles
  localparam logic [2:0] STORE_WIN    = 3'h4;
  localparam logic [2:0] LOAD_WIN_MIN = 3'h2;
  // flash geometry
  localparam int ADDR_W = 17;
  localparam int PAGE_W = 10;
  localparam int WORD_W = 7;
  localparam logic [PAGE_W-1:0] RWW_PAGES = 10'h3e0;
  // boot section start word per size fuse code
  localparam logic [ADDR_W-1:0] BOOT_START_11 = 17'h1fe00;
  localparam logic [ADDR_W-1:0] BOOT_START_10 = 17'h1fc00;
  localparam logic [ADDR_W-1:0] BOOT_START_01 = 17'h1f800;
  localparam logic [ADDR_W-1:0] BOOT_START_00 = 17'h1f000;
  // kinds of program load answer
  typedef enum logic [1:0] {
    LD_FLASH, LD_SIG, LD_LOCK, LD_FUSE
  } bspc_ld_e;
endpackage : bspc_pkg

/* shared/bspc_if.sv */
// link between the cpu core and the self-program controller
`timescale 1ns/100ps
interface bspc_if;
  logic       io_wr;
  logic       io_rd;
  logic [5:0] io_addr;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic       io_rvalid;
  logic       store;
  logic       load;
  logic [15:0] zptr;
  logic [7:0] r0;
  logic [7:0] r1;
  logic       glob_ie;
  logic [7:0] load_data;
  logic       load_valid;
  logic       irq;
  logic       stall;
  logic       op_busy;
  modport dev (
    input  io_wr, io_rd, io_addr, io_wdata, store, load, zptr, r0, r1,
    input  glob_ie,
    output io_rdata, io_rvalid, load_data, load_valid, irq, stall, op_busy
  );
  modport cpu (
    output io_wr, io_rd, io_addr, io_wdata, store, load, zptr, r0, r1,
    output glob_ie,
    input  io_rdata, io_rvalid, load_data, load_valid, irq, stall, op_busy
  );
endinterface : bspc_if

/* core/bspc_dev_end.sv */
// self-program controller, device end facing the flash array
`timescale 1ns/100ps
// Operation
// (RQ1) boot size fuses select boot start
// (RQ2) pages below 992 are read-while-write area
// (RQ3) 17-bit word address, 128-word pages
// (RQ4) page from upper pointer, word from bits 7:1
// (RQ5) pointer bit 0 is load byte select
// (RQ6) top page bit from extended pointer register; the code takes the top two page bits from it
// (RQ7) ready irq while enabled and idle
// (RQ8) busy flag set, area reads blocked
// (RQ9) busy cleared by re-enable or fill
// (RQ10) signature read window, stores ignored
// (RQ11) re-enable store restores area reads
// (RQ12) re-enable write discards temporary buffer
// (RQ13) lock-set store writes lock bits from r0
// (RQ14) lock-set load reads lock or fuse
// (RQ15) page-write store writes buffer to page
// (RQ16) page-erase store erases addressed page
// (RQ17) stall cpu for no-read-while-write operations
// (RQ18) plain enable store fills buffer word
// (RQ19) enable holds four cycles or operation
// (RQ20) only five command patterns accepted
// (RQ21) software keeps one store operation active
// (RQ22) store without enable changes nothing
module bspc_dev_end
  import bspc_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  // cpu side
  bspc_if.dev                    bus,
  // fuses and fixed rows
  input  wire logic              boot_size_fuse_hi_i,
  input  wire logic              boot_size_fuse_lo_i,
  input  wire logic [7:0]        sig_byte_i,
  input  wire logic [7:0]        lock_bits_i,
  input  wire logic [7:0]        fuse_bits_i,
  // flash array
  input  wire logic              flash_done_i,
  input  wire logic [15:0]       flash_rd_word_i,
  output logic [ADDR_W-1:0]      flash_rd_addr_o,
  output logic                   flash_erase_o,
  output logic                   flash_write_o,
  output logic [PAGE_W-1:0]      flash_page_o,
  output logic                   buf_load_o,
  output logic [WORD_W-1:0]      buf_word_o,
  output logic [15:0]            buf_data_o,
  output logic                   buf_discard_o,
  output logic                   lock_wr_o,
  output logic [7:0]             lock_data_o,
  output logic [ADDR_W-1:0]      boot_start_o,
  output logic                   section_busy_o
);
  logic              irq_en_r, busy_r, sig_r, op_r, stall_r, loaded_r;
  logic              irq_r, rvalid_r;
  logic [1:0]        ext_r;
  logic [4:0]        mode_r;
  logic [2:0]        win_r;
  logic [7:0]        rdata_r;
  logic              wr_ctrl, valid_cmd, arm, store_ok, win_end, clr_mode;
  logic              do_fill, do_reen, do_lock, do_prog, prog_rww, discard;
  logic              ld_win, ld_p1_r, ld_bsel_r, ld_block_r, ld_valid_r;
  logic [PAGE_W-1:0] st_page;
  logic [ADDR_W-1:0] ld_addr;
  logic [7:0]        ld_data_r;
  bspc_ld_e          ld_kind, ld_kind_r;

  // command decode
  always_comb begin
    wr_ctrl   = bus.io_wr && (bus.io_addr == CTRL_OFFSET);
    // (RQ20) pattern filter
    valid_cmd = (bus.io_wdata[4:0] == CMD_REEN) ||
                (bus.io_wdata[4:0] == CMD_LOCK) ||
                (bus.io_wdata[4:0] == CMD_PGWR) ||
                (bus.io_wdata[4:0] == CMD_PGER) ||
                (bus.io_wdata[4:0] == CMD_FILL);
    arm       = wr_ctrl && valid_cmd && !op_r;
    // (RQ22) store needs open window
    store_ok  = bus.store && mode_r[0] && (win_r != 3'h0) && !op_r;
    // (RQ18) plain buffer fill
    do_fill   = store_ok && !sig_r && (mode_r == CMD_FILL);
    // (RQ11) re-enable only when idle
    do_reen   = store_ok && (mode_r == CMD_REEN);
    do_lock   = store_ok && (mode_r == CMD_LOCK);
    do_prog   = store_ok && ((mode_r == CMD_PGWR) || (mode_r == CMD_PGER));
    // (RQ4) page index, with (RQ6) top two bits
    st_page   = {ext_r, bus.zptr[15:8]};
    // (RQ2) area split on page index
    prog_rww  = st_page < RWW_PAGES;
    win_end   = !op_r && (win_r == 3'h1) && !arm;
    clr_mode  = (store_ok && !do_prog) || win_end || (op_r && flash_done_i);
    // (RQ12) discard on re-enable store, or on re-enable write while loaded
    discard   = do_reen || (wr_ctrl && bus.io_wdata[BIT_REEN] && loaded_r);
  end

  // command bits; signature read only rides on the fill pattern
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mode_r <= CTRL_RESET[4:0];
      sig_r  <= CTRL_RESET[BIT_SIG];
    end else if (arm) begin
      mode_r <= bus.io_wdata[4:0];
      sig_r  <= bus.io_wdata[BIT_SIG] && (bus.io_wdata[4:0] == CMD_FILL);
    end else if (clr_mode) begin
      // (RQ13) self clear, same for (RQ15) (RQ16)
      mode_r <= 5'h00;
      sig_r  <= 1'b0;
    end
  end

  // irq enable and extended pointer are plain storage
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_en_r <= CTRL_RESET[BIT_IRQ_EN];
      ext_r    <= 2'h0;
    end else begin
      if (wr_ctrl) irq_en_r <= bus.io_wdata[BIT_IRQ_EN];
      if (bus.io_wr && (bus.io_addr == EXTPTR_OFFSET)) begin
        ext_r <= bus.io_wdata[1:0];
      end
    end
  end

  // (RQ19) four cycle window, frozen during operation
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      win_r <= 3'h0;
    end else if (arm) begin
      win_r <= STORE_WIN;
    end else if (store_ok) begin
      win_r <= 3'h0;
    end else if (!op_r && (win_r != 3'h0)) begin
      win_r <= win_r - 3'h1;
    end
  end

  // erase or write in flight until the array reports done
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      op_r          <= 1'b0;
      stall_r       <= 1'b0;
      flash_erase_o <= 1'b0;
      flash_write_o <= 1'b0;
      flash_page_o  <= '0;
    end else if (do_prog) begin
      op_r          <= 1'b1;
      // (RQ17) halt core on protected area
      stall_r       <= !prog_rww;
      // (RQ16) erase addressed page
      flash_erase_o <= (mode_r == CMD_PGER);
      // (RQ15) write buffer to page
      flash_write_o <= (mode_r == CMD_PGWR);
      flash_page_o  <= st_page;
    end else if (op_r && flash_done_i) begin
      op_r          <= 1'b0;
      stall_r       <= 1'b0;
      flash_erase_o <= 1'b0;
      flash_write_o <= 1'b0;
    end
  end

  // busy flag; hardware set cannot meet a clear in one cycle
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      busy_r <= CTRL_RESET[BIT_BUSY];
    end else if (do_prog && prog_rww) begin
      // (RQ8) set on area operation
      busy_r <= 1'b1;
    end else if (do_fill || do_reen) begin
      // (RQ9) cleared by fill or re-enable
      busy_r <= 1'b0;
    end
  end

  // temporary buffer and lock bit strobes
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      buf_load_o    <= 1'b0;
      buf_word_o    <= '0;
      buf_data_o    <= 16'h0000;
      buf_discard_o <= 1'b0;
      loaded_r      <= 1'b0;
      lock_wr_o     <= 1'b0;
      lock_data_o   <= 8'h00;
    end else begin
      buf_load_o    <= do_fill;
      buf_discard_o <= discard;
      lock_wr_o     <= do_lock;
      if (do_fill) begin
        // (RQ4) word index from pointer bits 7:1
        buf_word_o <= bus.zptr[7:1];
        buf_data_o <= {bus.r1, bus.r0};
      end
      // (RQ13) lock bits from r0 only
      if (do_lock) lock_data_o <= bus.r0;
      if (do_fill) begin
        loaded_r <= 1'b1;
      end else if (discard || (do_prog && mode_r == CMD_PGWR)) begin
        loaded_r <= 1'b0;
      end
    end
  end

  // (RQ7) ready irq level
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) irq_r <= 1'b0;
    else irq_r <= irq_en_r && bus.glob_ie && !mode_r[0];
  end

  // register read answers one cycle later
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 8'h00;
    end else begin
      rvalid_r <= bus.io_rd;
      if (bus.io_addr == CTRL_OFFSET) begin
        rdata_r <= {irq_en_r, busy_r, sig_r, mode_r};
      end else if (bus.io_addr == EXTPTR_OFFSET) begin
        rdata_r <= {6'h00, ext_r};
      end else begin
        rdata_r <= UNMAPPED_BYTE;
      end
    end
  end

  // load path: kind and address decided at request
  always_comb begin
    // (RQ10) three cycle load window
    ld_win  = mode_r[0] && (win_r >= LOAD_WIN_MIN) && !op_r;
    // (RQ3) word address from page and word index
    ld_addr = {ext_r, bus.zptr[15:1]};
    if (ld_win && sig_r) begin
      ld_kind = LD_SIG;
    end else if (ld_win && (mode_r == CMD_LOCK)) begin
      // (RQ14) pointer bit 0 picks fuse or lock
      ld_kind = bus.zptr[0] ? LD_FUSE : LD_LOCK;
    end else begin
      ld_kind = LD_FLASH;
    end
  end

  // two stage load: address out, then byte back
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ld_p1_r         <= 1'b0;
      ld_kind_r       <= LD_FLASH;
      ld_bsel_r       <= 1'b0;
      ld_block_r      <= 1'b0;
      flash_rd_addr_o <= '0;
      ld_valid_r      <= 1'b0;
      ld_data_r       <= 8'h00;
    end else begin
      ld_p1_r    <= bus.load;
      ld_valid_r <= ld_p1_r;
      if (bus.load) begin
        ld_kind_r       <= ld_kind;
        // (RQ5) byte select within word
        ld_bsel_r       <= bus.zptr[0];
        // (RQ8) area reads blocked while busy
        ld_block_r      <= busy_r && (ld_addr[16:7] < RWW_PAGES);
        flash_rd_addr_o <= ld_addr;
      end
      if (ld_p1_r) begin
        case (ld_kind_r)
          LD_SIG:  ld_data_r <= sig_byte_i;
          LD_LOCK: ld_data_r <= lock_bits_i;
          LD_FUSE: ld_data_r <= fuse_bits_i;
          LD_FLASH: begin
            if (ld_block_r) ld_data_r <= BLOCKED_BYTE;
            else if (ld_bsel_r) ld_data_r <= flash_rd_word_i[15:8];
            else ld_data_r <= flash_rd_word_i[7:0];
          end
          default: ld_data_r <= 8'h00;
        endcase
      end
    end
  end

  // (RQ1) boot start from size fuses
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      boot_start_o <= BOOT_START_00;
    end else begin
      case ({boot_size_fuse_hi_i, boot_size_fuse_lo_i})
        2'b11:   boot_start_o <= BOOT_START_11;
        2'b10:   boot_start_o <= BOOT_START_10;
        2'b01:   boot_start_o <= BOOT_START_01;
        default: boot_start_o <= BOOT_START_00;
      endcase
    end
  end

  // interface outputs, all from flops
  assign bus.io_rdata     = rdata_r;
  assign bus.io_rvalid    = rvalid_r;
  assign bus.load_data    = ld_data_r;
  assign bus.load_valid   = ld_valid_r;
  assign bus.irq          = irq_r;
  assign bus.stall        = stall_r;
  assign bus.op_busy      = op_r;
  assign section_busy_o   = busy_r;
endmodule : bspc_dev_end

/* core/bspc_cpu_end.sv */
// self-program controller, cpu core end
`timescale 1ns/100ps
module bspc_cpu_end
  import bspc_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // link to the controller
  bspc_if.cpu              bus,
  // core requests
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [5:0]  io_addr_i,
  input  wire logic [7:0]  io_wdata_i,
  input  wire logic        store_i,
  input  wire logic        load_i,
  input  wire logic [15:0] z_i,
  input  wire logic [7:0]  r0_i,
  input  wire logic [7:0]  r1_i,
  input  wire logic        glob_ie_i,
  // answers to the core
  output logic [7:0]       io_rdata_o,
  output logic             io_rvalid_o,
  output logic [7:0]       load_data_o,
  output logic             load_valid_o,
  output logic             irq_o,
  output logic             stall_o,
  output logic             refused_o
);
  logic io_wr_r, io_rd_r, store_r, load_r, ie_r, pgwr_armed_r;
  logic [5:0]  addr_r;
  logic [7:0]  wdata_r, r0_r, r1_r;
  logic [15:0] z_r;
  logic        take, ctrl_wr, wr_ok;

  // no request goes out while stalled; no arming during an operation
  always_comb begin
    take    = !bus.stall;
    ctrl_wr = io_wr_i && (io_addr_i == CTRL_OFFSET);
    // (RQ11) wait for completion first
    wr_ok   = io_wr_i && take && !(ctrl_wr && bus.op_busy);
  end

  // request stage toward the controller
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      io_wr_r <= 1'b0;
      io_rd_r <= 1'b0;
      store_r <= 1'b0;
      load_r  <= 1'b0;
      addr_r  <= 6'h00;
      wdata_r <= 8'h00;
      z_r     <= 16'h0000;
      r0_r    <= 8'h00;
      r1_r    <= 8'h00;
      ie_r    <= 1'b0;
    end else begin
      io_wr_r <= wr_ok;
      io_rd_r <= io_rd_i && take;
      // (RQ21) one store operation at a time
      store_r <= store_i && take && !bus.op_busy;
      load_r  <= load_i && take;
      ie_r    <= glob_ie_i;
      if (io_wr_i || io_rd_i) begin
        addr_r  <= io_addr_i;
        wdata_r <= io_wdata_i;
      end
      if (store_i) begin
        // (RQ5) bit 0 zero, (RQ4) word zero on page write
        z_r  <= {z_i[15:8], pgwr_armed_r ? 7'h00 : z_i[7:1], 1'b0};
        r0_r <= r0_i;
        r1_r <= r1_i;
      end else if (load_i) begin
        z_r <= z_i;
      end
    end
  end

  // remembers an armed page write until the next store
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pgwr_armed_r <= 1'b0;
    end else if (wr_ok && ctrl_wr) begin
      pgwr_armed_r <= (io_wdata_i[4:0] == CMD_PGWR);
    end else if (store_i && take) begin
      pgwr_armed_r <= 1'b0;
    end
  end

  // answers back to the core
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      io_rdata_o   <= 8'h00;
      io_rvalid_o  <= 1'b0;
      load_data_o  <= 8'h00;
      load_valid_o <= 1'b0;
      irq_o        <= 1'b0;
      stall_o      <= 1'b0;
      refused_o    <= 1'b0;
    end else begin
      io_rdata_o   <= bus.io_rdata;
      io_rvalid_o  <= bus.io_rvalid;
      load_data_o  <= bus.load_data;
      load_valid_o <= bus.load_valid;
      irq_o        <= bus.irq;
      stall_o      <= bus.stall;
      refused_o    <= ((io_wr_i && !wr_ok) ||
                       ((io_rd_i || load_i || store_i) && !take) ||
                       (store_i && bus.op_busy));
    end
  end

  assign bus.io_wr    = io_wr_r;
  assign bus.io_rd    = io_rd_r;
  assign bus.io_addr  = addr_r;
  assign bus.io_wdata = wdata_r;
  assign bus.store    = store_r;
  assign bus.load     = load_r;
  assign bus.zptr     = z_r;
  assign bus.r0       = r0_r;
  assign bus.r1       = r1_r;
  assign bus.glob_ie  = ie_r;
endmodule : bspc_cpu_end

/* tb/bspc_link_sva.sv */
// concurrent checks on the link between the two controller ends
`timescale 1ns/100ps
module bspc_link_sva
  import bspc_pkg::*;
(
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  // link signals seen by both ends
  input wire logic        io_rd,
  input wire logic [5:0]  io_addr,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rvalid,
  input wire logic        store,
  input wire logic        load,
  input wire logic [15:0] zptr,
  input wire logic        glob_ie,
  input wire logic        load_valid,
  input wire logic        irq,
  input wire logic        stall,
  input wire logic        op_busy
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // register read answers exactly one cycle later
  a_read_answer: assert property (io_rd |=> io_rvalid)
    else $error("read answer missing");
  a_read_cause: assert property (io_rvalid |-> $past(io_rd))
    else $error("read answer without request");
  a_load_answer: assert property (load |-> ##2 load_valid)
    else $error("load answer late");
  a_load_cause: assert property (load_valid |-> $past(load, 2))
    else $error("load answer without load");
  a_irq_global: assert property (irq |-> $past(glob_ie))
    else $error("ready irq without global enable");
  // enable stays set while an operation runs, so no ready irq then
  a_irq_in_op: assert property (op_busy && $past(op_busy) |-> !irq)
    else $error("ready irq during operation");
  a_stall_in_op: assert property (stall |-> op_busy)
    else $error("stall outside operation");
  a_op_from_store: assert property ($rose(op_busy) |-> $past(store))
    else $error("operation started without store");
  // only the top 32 pages can stall the core
  a_stall_no_read_while_write_area: assert property ($rose(stall) |-> &$past(zptr[15:13]))
    else $error("stall for read-while-write page");
  a_enable_held: assert property (
    io_rd && io_addr == CTRL_OFFSET && op_busy |=> io_rdata[0])
    else $error("enable dropped during operation");

  // main scenarios reached
  c_stall: cover property ($rose(stall));
  c_rww_op: cover property ($rose(op_busy) && !stall);
  c_load: cover property (load_valid);
endmodule : bspc_link_sva

/* tb/boot_self_program_ctrl_test.sv */
// self-checking bench joining the cpu end and the device end
`timescale 1ns/100ps
module boot_self_program_ctrl_test;
  import bspc_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        io_wr_i = 1'b0, io_rd_i = 1'b0, store_i = 1'b0;
  logic        load_i = 1'b0, glob_ie_i = 1'b1, flash_done_i = 1'b0;
  logic        boot_size_fuse_hi_i = 1'b1, boot_size_fuse_lo_i = 1'b1;
  logic [5:0]  io_addr_i = 6'h00;
  logic [7:0]  io_wdata_i = 8'h00, r0_i = 8'h00, r1_i = 8'h00;
  logic [7:0]  sig_byte_i = 8'h3c, lock_bits_i = 8'hc3;
  logic [7:0]  fuse_bits_i = 8'h5a;
  logic [15:0] z_i = 16'h0000;
  wire  [15:0] flash_rd_word_i;
  logic [7:0]  io_rdata_o, load_data_o, lock_data_o, rd, lk, lk_exp, v;
  logic        io_rvalid_o, load_valid_o, irq_o, stall_o, saw_stall;
  logic        flash_erase_o, flash_write_o, buf_load_o, buf_discard_o;
  logic        lock_wr_o, section_busy_o, refused_o;
  logic [16:0] flash_rd_addr_o, boot_start_o;
  logic [9:0]  flash_page_o, op_page;
  logic [6:0]  buf_word_o;
  logic [15:0] buf_data_o, d;
  logic [15:0] pg [0:127];
  logic [15:0] tbbuf [0:127];
  logic [15:0] exp_buf [0:3];
  logic [16:0] bs [0:3] = '{BOOT_START_00, BOOT_START_01,
                            BOOT_START_10, BOOT_START_11};
  integer      fail_count = 0, comparisons = 0, seed = 32'h909a;
  integer      n_fill = 0, n_disc = 0, n_lock = 0, op_cnt = 0, n_ref = 0;
  integer      cyc_cnt = 0, f0, d0;

  always #5 core_clk_i = ~core_clk_i;

  bspc_if bus ();
  bspc_cpu_end u_bspc_cpu_end (.core_clk_i, .rst_n_i, .bus, .io_wr_i,
    .io_rd_i, .io_addr_i, .io_wdata_i, .store_i, .load_i, .z_i, .r0_i,
    .r1_i, .glob_ie_i, .io_rdata_o, .io_rvalid_o, .load_data_o,
    .load_valid_o, .irq_o, .stall_o, .refused_o);
  bspc_dev_end u_bspc_dev_end (.core_clk_i, .rst_n_i, .bus,
    .boot_size_fuse_hi_i, .boot_size_fuse_lo_i, .sig_byte_i, .lock_bits_i,
    .fuse_bits_i, .flash_done_i, .flash_rd_word_i, .flash_rd_addr_o,
    .flash_erase_o, .flash_write_o, .flash_page_o, .buf_load_o,
    .buf_word_o, .buf_data_o, .buf_discard_o, .lock_wr_o, .lock_data_o,
    .boot_start_o, .section_busy_o);
  bspc_link_sva u_bspc_link_sva (.core_clk_i, .rst_n_i, .io_rd(bus.io_rd),
    .io_addr(bus.io_addr), .io_rdata(bus.io_rdata),
    .io_rvalid(bus.io_rvalid), .store(bus.store), .load(bus.load),
    .zptr(bus.zptr), .glob_ie(bus.glob_ie), .load_valid(bus.load_valid),
    .irq(bus.irq), .stall(bus.stall), .op_busy(bus.op_busy));

  // one flash page, fed only by what the device end asks for
  assign flash_rd_word_i = pg[flash_rd_addr_o[6:0]];

  // array, buffer and done pulse; slow enough to see the stall
  always @(posedge core_clk_i) begin
    flash_done_i <= 1'b0;
    op_cnt <= (flash_erase_o | flash_write_o) ? op_cnt + 1 : 0;
    if (op_cnt == 5) flash_done_i <= 1'b1;
    if (flash_erase_o | flash_write_o) op_page = flash_page_o;
    for (int i = 0; i < 128; i++) begin
      if (flash_erase_o && op_cnt == 0) pg[i] = 16'hffff;
      if (flash_write_o && op_cnt == 0) pg[i] = tbbuf[i];
      if (buf_discard_o) tbbuf[i] = 16'hffff;
    end
    if (buf_load_o) tbbuf[buf_word_o] = buf_data_o;
    if (lock_wr_o) lk = lock_data_o;
    // outputs are unknown before the first reset edge
    if (rst_n_i) begin
      n_fill += buf_load_o;
      n_disc += buf_discard_o;
      n_lock += lock_wr_o;
      n_ref += refused_o;
    end
    if (stall_o) saw_stall = 1'b1;
    cyc_cnt++;
    // hang guard, well above the length of the whole sequence
    if (cyc_cnt == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : cyc

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_ev(input integer got, input integer exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %0d events, expected %0d", $time, got, exp);
    end
  endtask : chk_ev

  // bounded wait for a read or load answer at the cpu end
  task automatic answer(input bit ld, output logic [7:0] q);
    int i;
    i = 0;
    while ((ld ? load_valid_o : io_rvalid_o) !== 1'b1 && i < 12) begin
      @(posedge core_clk_i);
      #1;
      i++;
    end
    q = ld ? load_data_o : io_rdata_o;
  endtask : answer

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] q);
    @(posedge core_clk_i);
    io_wr_i <= 1'b1;
    io_addr_i <= a;
    io_wdata_i <= q;
    @(posedge core_clk_i);
    io_wr_i <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [5:0] a, output logic [7:0] q);
    @(posedge core_clk_i);
    io_rd_i <= 1'b1;
    io_addr_i <= a;
    @(posedge core_clk_i);
    io_rd_i <= 1'b0;
    answer(1'b0, q);
  endtask : rd_reg

  // store or load with its pointer and data held for the request cycle
  task automatic xfer(input bit ld, input logic [15:0] z,
                      input logic [15:0] w, output logic [7:0] q);
    @(posedge core_clk_i);
    if (ld) load_i <= 1'b1;
    else store_i <= 1'b1;
    z_i <= z;
    {r1_i, r0_i} <= w;
    @(posedge core_clk_i);
    load_i <= 1'b0;
    store_i <= 1'b0;
    q = 8'h00;
    if (ld) answer(1'b1, q);
  endtask : xfer

  task automatic cmd(input logic [4:0] c, input logic [15:0] z,
                     input logic [15:0] w);
    wr_reg(CTRL_OFFSET, {3'h0, c});
    xfer(1'b0, z, w, rd);
    cyc(3);
  endtask : cmd

  // bounded wait for an erase or write to start and finish
  task automatic wait_op;
    int i;
    i = 0;
    while (!(flash_erase_o | flash_write_o) && i < 10) begin
      @(posedge core_clk_i);
      #1;
      i++;
    end
    while ((flash_erase_o | flash_write_o) && i < 40) begin
      @(posedge core_clk_i);
      #1;
      i++;
    end
    cyc(4);
  endtask : wait_op

  task automatic report_and_stop;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // main sequence
  initial begin
    for (int i = 0; i < 128; i++) pg[i] = 16'h0000;
    cyc(5);
    rst_n_i <= 1'b1;
    rd_reg(CTRL_OFFSET, rd);
    chk(rd, CTRL_RESET);
    rd_reg(6'h20, rd);
    chk(rd, UNMAPPED_BYTE);
    for (int c = 0; c < 4; c++) begin
      {boot_size_fuse_hi_i, boot_size_fuse_lo_i} <= c[1:0];
      cyc(3);
      chk(boot_start_o, bs[c]);
    end
    // random refused patterns still write the irq enable
    repeat (6) begin
      v = $random(seed);
      if (v[4:0] inside {CMD_REEN, CMD_LOCK, CMD_PGWR, CMD_PGER, CMD_FILL})
        v[4:0] = 5'h02;
      glob_ie_i <= v[6];
      wr_reg(CTRL_OFFSET, v);
      cyc(2);
      rd_reg(CTRL_OFFSET, rd);
      chk(rd, {v[7], 7'h00});
      chk(irq_o, v[7] & v[6]);
    end
    wr_reg(CTRL_OFFSET, {3'h0, CMD_FILL});
    rd_reg(CTRL_OFFSET, rd);
    chk(rd, 8'h01);
    cyc(6);
    rd_reg(CTRL_OFFSET, rd);
    chk(rd, 8'h00);
    xfer(1'b0, 16'h0002, 16'h1122, rd);
    cyc(4);
    chk_ev(n_fill, 0);
    wr_reg(EXTPTR_OFFSET, 8'h03);
    rd_reg(EXTPTR_OFFSET, rd);
    chk(rd, 8'h03);
    saw_stall = 1'b0;
    cmd(CMD_PGER, 16'he000, 16'h0000);
    // store while the core is stalled must be refused
    xfer(1'b0, 16'he000, 16'h0000, rd);
    wait_op;
    chk(saw_stall, 1'b1);
    chk_ev(n_ref, 1);
    chk(op_page, 10'h3e0);
    chk(section_busy_o, 1'b0);
    wr_reg(EXTPTR_OFFSET, 8'h00);
    cmd(CMD_FILL, 16'h0502, 16'hbeef);
    d0 = n_disc;
    wr_reg(CTRL_OFFSET, 8'h10);
    cyc(3);
    chk_ev(n_disc, d0 + 1);
    saw_stall = 1'b0;
    cmd(CMD_PGER, 16'h0500, 16'h0000);
    rd_reg(CTRL_OFFSET, rd);
    chk(rd, 8'h43);
    wait_op;
    chk(op_page, 10'h005);
    chk(section_busy_o, 1'b1);
    chk(saw_stall, 1'b0);
    rd_reg(CTRL_OFFSET, rd);
    chk(rd, 8'h40);
    xfer(1'b1, 16'h0500, 16'h0000, rd);
    chk(rd, BLOCKED_BYTE);
    f0 = n_fill;
    for (int w = 0; w < 4; w++) begin
      d = $random(seed);
      exp_buf[w] = d;
      cmd(CMD_FILL, {8'h05, w[6:0], 1'b1}, d);
    end
    chk_ev(n_fill - f0, 4);
    chk(section_busy_o, 1'b0);
    cmd(CMD_PGWR, 16'h0500, 16'h7777);
    wait_op;
    chk(op_page, 10'h005);
    chk(section_busy_o, 1'b1);
    cmd(CMD_REEN, 16'h0000, 16'h0000);
    chk(section_busy_o, 1'b0);
    for (int k = 0; k < 8; k++) begin
      xfer(1'b1, {8'h05, k[7:1], k[0]}, 16'h0000, rd);
      d = exp_buf[k[2:1]];
      chk(rd, k[0] ? d[15:8] : d[7:0]);
    end
    lk_exp = $random(seed);
    cmd(CMD_LOCK, 16'h1234, {8'h5a, lk_exp});
    chk_ev(n_lock, 1);
    chk(lk, lk_exp);
    for (int k = 0; k < 2; k++) begin
      wr_reg(CTRL_OFFSET, {3'h0, CMD_LOCK});
      xfer(1'b1, {15'h0000, k[0]}, 16'h0000, rd);
      chk(rd, k[0] ? fuse_bits_i : lock_bits_i);
    end
    rd_reg(CTRL_OFFSET, rd);
    chk(rd, 8'h00);
    f0 = n_fill;
    wr_reg(CTRL_OFFSET, 8'h21);
    xfer(1'b1, 16'h0000, 16'h0000, rd);
    chk(rd, sig_byte_i);
    cmd(5'h01 | 5'h00, 16'h0000, 16'h0000);
    f0 = n_fill;
    wr_reg(CTRL_OFFSET, 8'h21);
    xfer(1'b0, 16'h0004, 16'h4321, rd);
    cyc(4);
    chk_ev(n_fill, f0);
    report_and_stop();
  end
endmodule : boot_self_program_ctrl_test
